// *** logic/uof_event_flags.sv ***
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ns
module uof_event_flags #(
  parameter int CYC_1MS = uof_pkg::UOF_CYC_1MS,
  parameter int CYC_IDLE = uof_pkg::UOF_CYC_IDLE
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // line and vbus monitors
  input wire logic id_pin,
  input wire logic line_se0,
  input wire logic j_line_state,
  input wire logic line_diff,
  input wire logic bus_activity,
  input wire logic bus_idle,
  input wire logic above_a_session_end_threshold,
  input wire logic above_b_session_end_threshold,
  input wire logic above_a_vbus_valid_threshold,
  // protocol engine events
  input wire logic stall_sent,
  input wire logic token_done,
  input wire logic [7:0] token_info,
  input wire logic frame_start,
  input wire logic [7:0] error_flags,
  input wire logic [7:0] error_event_enables,
  // interrupt request
  output logic irq
);
  import uof_pkg::*;

  localparam logic [15:0] LIM_1MS = 16'(CYC_1MS);
  localparam logic [15:0] LIM_IDLE = 16'(CYC_IDLE);
  localparam logic [15:0] LIM_2P5US = 16'(UOF_CYC_2P5US);

  // saturating run-length counter
  function automatic logic [15:0] uof_run(input logic run,
      input logic [15:0] cnt, input logic [15:0] lim);
    logic [15:0] r;
    r = 16'h0000;
    if (run) begin
      r = (cnt == lim) ? lim : 16'(cnt + 16'h0001);
    end
    return r;
  endfunction : uof_run

  // true on the cycle a run first reaches its limit
  function automatic logic uof_hit(input logic run,
      input logic [15:0] cnt, input logic [15:0] lim);
    return run && (cnt == 16'(lim - 16'h0001));
  endfunction : uof_hit

  logic [7:0] otg_flags_reg;
  logic [7:0] otg_event_enables_reg;
  logic [7:0] usb_flags_reg;
  logic [7:0] usb_event_enables_reg;
  logic [7:0] transfer_status_reg;
  logic [7:0] mode_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wlane0_reg;
  logic id_prev_reg;
  logic a_sess_prev_reg;
  logic b_sess_prev_reg;
  logic a_vld_prev_reg;
  logic [1:0] line_prev_reg;
  logic [1:0] line_stable_reg;
  logic [15:0] ms_cnt_reg;
  logic [15:0] line_cnt_reg;
  logic [15:0] idle_cnt_reg;
  logic [15:0] resume_cnt_reg;
  logic [15:0] attach_cnt_reg;
  logic [15:0] se0_cnt_reg;
  uof_se0_state_t se0_state_reg;
  uof_se0_state_t se0_state_next;

  logic host_mode;
  logic low_speed;
  logic wr_go;
  logic wr_lane;
  logic [1:0] line_now;
  logic k_state;
  logic attach_run;
  logic ms_tick;
  logic line_hit;
  logic se0_hit;
  logic [7:0] otg_set;
  logic [7:0] usb_set;
  logic [7:0] otg_clr;
  logic [7:0] usb_clr;
  logic [7:0] usb_en_eff;
  logic [7:0] rd_val;
  logic rd_ok;

  assign host_mode = mode_reg[UOF_HOST_MODE_BIT];
  assign low_speed = mode_reg[UOF_LOW_SPEED_BIT];
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_lane = wr_go && wlane0_reg;
  assign line_now = {line_se0, j_line_state};
  // low speed k is differential one, full speed differential zero
  assign k_state = !line_se0 && (line_diff == low_speed);
  assign attach_run = host_mode && !line_se0 && !bus_activity;
  assign ms_tick = (ms_cnt_reg == 16'(LIM_1MS - 16'h0001));
  // a change on the last counted sample must not count as stable
  assign line_hit = uof_hit(line_now == line_prev_reg, line_cnt_reg,
    LIM_1MS) && (line_now != line_stable_reg);
  assign se0_hit = (se0_state_reg == UOF_SE0_TIMING) && line_se0
    && uof_hit(1'b1, se0_cnt_reg, LIM_2P5US);

  // hardware set terms; otg events only in host mode
  always_comb begin
    otg_set = 8'h00;
    if (host_mode) begin
      otg_set[UOF_ID_CHANGE_BIT] = id_pin != id_prev_reg;
      otg_set[UOF_MS_TIMER_BIT] = ms_tick;
      otg_set[UOF_LINE_STABLE_BIT] = line_hit;
      otg_set[UOF_ACTIVITY_BIT] = bus_activity;
      // either crossing direction is an event
      otg_set[UOF_SESS_VALID_BIT] =
        above_a_session_end_threshold != a_sess_prev_reg;
      otg_set[UOF_B_SESS_END_BIT] =
        above_b_session_end_threshold != b_sess_prev_reg;
      otg_set[UOF_A_VBUS_VALID_BIT] =
        above_a_vbus_valid_threshold != a_vld_prev_reg;
    end
  end

  always_comb begin
    usb_set = 8'h00;
    usb_set[UOF_STALL_BIT] = stall_sent;
    usb_set[UOF_ATTACH_BIT] =
      uof_hit(attach_run, attach_cnt_reg, LIM_2P5US);
    usb_set[UOF_RESUME_BIT] =
      uof_hit(k_state, resume_cnt_reg, LIM_2P5US);
    usb_set[UOF_IDLE_BIT] =
      uof_hit(bus_idle, idle_cnt_reg, LIM_IDLE);
    usb_set[UOF_TOKEN_DONE_BIT] = token_done;
    usb_set[UOF_FRAME_START_BIT] = frame_start;
    usb_set[UOF_ERROR_SUM_BIT] =
      |(error_flags & error_event_enables);
    // one bit serves reset in device mode and detach in host mode
    usb_set[UOF_RESET_DETACH_BIT] = se0_hit;
  end

  // write-one-to-clear masks from the low byte lane only
  always_comb begin
    otg_clr = 8'h00;
    usb_clr = 8'h00;
    if (wr_lane && awaddr_reg == UOF_OTG_FLAGS_ADDR) begin
      otg_clr = wdata_reg;
    end
    if (wr_lane && awaddr_reg == UOF_USB_FLAGS_ADDR) begin
      usb_clr = wdata_reg;
    end
  end

  // attach enable ignored outside host mode
  always_comb begin
    usb_en_eff = usb_event_enables_reg;
    usb_en_eff[UOF_ATTACH_BIT] = usb_event_enables_reg[UOF_ATTACH_BIT]
      && host_mode;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      otg_flags_reg <= UOF_FLAGS_RESET;
      usb_flags_reg <= UOF_FLAGS_RESET;
    end else begin
      otg_flags_reg <= ((otg_flags_reg & ~otg_clr) | otg_set)
        & UOF_OTG_IMPL_MASK;
      usb_flags_reg <= (usb_flags_reg & ~usb_clr) | usb_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      otg_event_enables_reg <= UOF_ENABLES_RESET;
      usb_event_enables_reg <= UOF_ENABLES_RESET;
      mode_reg <= UOF_MODE_RESET;
    end else if (wr_lane) begin
      unique case (awaddr_reg)
        UOF_OTG_ENABLES_ADDR: begin
          otg_event_enables_reg <= wdata_reg & UOF_OTG_IMPL_MASK;
        end
        UOF_USB_ENABLES_ADDR: begin
          usb_event_enables_reg <= wdata_reg;
        end
        UOF_MODE_CTRL_ADDR: begin
          mode_reg <= wdata_reg & UOF_MODE_IMPL_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // endpoint information captured with each finished token
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transfer_status_reg <= 8'h00;
    end else if (token_done) begin
      transfer_status_reg <= token_info;
    end
  end

  // previous samples for change detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      id_prev_reg <= 1'b0;
      a_sess_prev_reg <= 1'b0;
      b_sess_prev_reg <= 1'b0;
      a_vld_prev_reg <= 1'b0;
      line_prev_reg <= 2'h0;
    end else begin
      id_prev_reg <= id_pin;
      a_sess_prev_reg <= above_a_session_end_threshold;
      b_sess_prev_reg <= above_b_session_end_threshold;
      a_vld_prev_reg <= above_a_vbus_valid_threshold;
      line_prev_reg <= line_now;
    end
  end

  // free running 1 ms timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_reg <= 16'h0000;
    end else if (ms_tick) begin
      ms_cnt_reg <= 16'h0000;
    end else begin
      ms_cnt_reg <= 16'(ms_cnt_reg + 16'h0001);
    end
  end

  // line state stability and last recorded stable state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_cnt_reg <= 16'h0000;
      line_stable_reg <= 2'h0;
    end else begin
      line_cnt_reg <= uof_run(line_now == line_prev_reg, line_cnt_reg,
        LIM_1MS);
      if (line_hit) begin
        line_stable_reg <= line_now;
      end
    end
  end

  // run-length counters for resume, idle and attach
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume_cnt_reg <= 16'h0000;
      idle_cnt_reg <= 16'h0000;
      attach_cnt_reg <= 16'h0000;
    end else begin
      resume_cnt_reg <= uof_run(k_state, resume_cnt_reg, LIM_2P5US);
      idle_cnt_reg <= uof_run(bus_idle, idle_cnt_reg, LIM_IDLE);
      attach_cnt_reg <= uof_run(attach_run, attach_cnt_reg, LIM_2P5US);
    end
  end

  // se0 hold: flag once, then wait for se0 to end before rearming
  always_comb begin
    se0_state_next = se0_state_reg;
    unique case (se0_state_reg)
      UOF_SE0_OFF: begin
        if (line_se0) begin
          se0_state_next = UOF_SE0_TIMING;
        end
      end
      UOF_SE0_TIMING: begin
        if (!line_se0) begin
          se0_state_next = UOF_SE0_OFF;
        end else if (se0_hit) begin
          se0_state_next = UOF_SE0_HELD;
        end
      end
      UOF_SE0_HELD: begin
        if (!line_se0) begin
          se0_state_next = UOF_SE0_OFF;
        end
      end
      default: begin
        se0_state_next = UOF_SE0_OFF;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      se0_state_reg <= UOF_SE0_OFF;
      se0_cnt_reg <= 16'h0000;
    end else begin
      se0_state_reg <= se0_state_next;
      se0_cnt_reg <= uof_run(se0_state_next == UOF_SE0_TIMING,
        se0_cnt_reg, LIM_2P5US);
    end
  end

  // interrupt request, otg sources only in host mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(usb_flags_reg & usb_en_eff)
        || (host_mode && |(otg_flags_reg & otg_event_enables_reg));
    end
  end

  // axi write channels taken independently, then answered together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wlane0_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= UOF_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wlane0_reg <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg > UOF_MODE_CTRL_ADDR
          || awaddr_reg[1:0] != 2'h0) ? UOF_RESP_SLVERR : UOF_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux; attach bit hidden in device mode
  always_comb begin
    rd_val = 8'h00;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      UOF_OTG_FLAGS_ADDR: rd_val = otg_flags_reg;
      UOF_OTG_ENABLES_ADDR: rd_val = otg_event_enables_reg;
      UOF_USB_FLAGS_ADDR: begin
        rd_val = usb_flags_reg;
        rd_val[UOF_ATTACH_BIT] = usb_flags_reg[UOF_ATTACH_BIT]
          && host_mode;
      end
      UOF_USB_ENABLES_ADDR: rd_val = usb_event_enables_reg;
      UOF_XFER_STATUS_ADDR: rd_val = transfer_status_reg;
      UOF_MODE_CTRL_ADDR: rd_val = mode_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= UOF_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_val};
        s_axi_rresp <= rd_ok ? UOF_RESP_OKAY : UOF_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : uof_event_flags

// *** pkg/uof_pkg.sv ***
package uof_pkg;
  // register byte addresses
  localparam logic [7:0] UOF_OTG_FLAGS_ADDR = 8'h00;
  localparam logic [7:0] UOF_OTG_ENABLES_ADDR = 8'h04;
  localparam logic [7:0] UOF_USB_FLAGS_ADDR = 8'h08;
  localparam logic [7:0] UOF_USB_ENABLES_ADDR = 8'h0C;
  localparam logic [7:0] UOF_XFER_STATUS_ADDR = 8'h10;
  localparam logic [7:0] UOF_MODE_CTRL_ADDR = 8'h14;
  // otg flag / enable bit positions
  localparam int UOF_ID_CHANGE_BIT = 7;
  localparam int UOF_MS_TIMER_BIT = 6;
  localparam int UOF_LINE_STABLE_BIT = 5;
  localparam int UOF_ACTIVITY_BIT = 4;
  localparam int UOF_SESS_VALID_BIT = 3;
  localparam int UOF_B_SESS_END_BIT = 2;
  localparam int UOF_A_VBUS_VALID_BIT = 0;
  localparam logic [7:0] UOF_OTG_IMPL_MASK = 8'hFD;
  // usb flag / enable bit positions
  localparam int UOF_STALL_BIT = 7;
  localparam int UOF_ATTACH_BIT = 6;
  localparam int UOF_RESUME_BIT = 5;
  localparam int UOF_IDLE_BIT = 4;
  localparam int UOF_TOKEN_DONE_BIT = 3;
  localparam int UOF_FRAME_START_BIT = 2;
  localparam int UOF_ERROR_SUM_BIT = 1;
  localparam int UOF_RESET_DETACH_BIT = 0;
  // mode control bit positions
  localparam int UOF_HOST_MODE_BIT = 0;
  localparam int UOF_LOW_SPEED_BIT = 1;
  localparam logic [7:0] UOF_MODE_IMPL_MASK = 8'h03;
  // reset values
  localparam logic [7:0] UOF_FLAGS_RESET = 8'h00;
  localparam logic [7:0] UOF_ENABLES_RESET = 8'h00;
  localparam logic [7:0] UOF_MODE_RESET = 8'h00;
  // axi responses
  localparam logic [1:0] UOF_RESP_OKAY = 2'h0;
  localparam logic [1:0] UOF_RESP_SLVERR = 2'h2;
  // timing
  localparam int UOF_CLK_NS = 50;
  localparam int UOF_T_1MS_NS = 1000000;
  localparam int UOF_T_2P5US_NS = 2500;
  localparam int UOF_T_IDLE_NS = 3000000;
  localparam int UOF_CYC_1MS = UOF_T_1MS_NS / UOF_CLK_NS;
  localparam int UOF_CYC_2P5US = (UOF_T_2P5US_NS + UOF_CLK_NS - 1)
    / UOF_CLK_NS;
  localparam int UOF_CYC_IDLE = (UOF_T_IDLE_NS + UOF_CLK_NS - 1)
    / UOF_CLK_NS;
  // se0 hold tracker for bus reset / detach
  typedef enum logic [1:0] {
    UOF_SE0_OFF,
    UOF_SE0_TIMING,
    UOF_SE0_HELD
  } uof_se0_state_t;
endpackage : uof_pkg

// *** sim/tb.sv ***
`timescale 1ns/1ns
module tb;
  import uof_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, id_pin, line_se0, j_line_state, line_diff;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, d;
  logic bus_activity, bus_idle, above_a_session_end_threshold;
  logic above_b_session_end_threshold, above_a_vbus_valid_threshold;
  logic stall_sent = 1'b0, token_done = 1'b0, frame_start = 1'b0;
  logic [7:0] token_info = 8'h00, error_flags = 8'h00;
  logic [7:0] error_event_enables = 8'h00;
  logic [31:0] rnd = 32'h0000002A;
  logic [1:0] r;
  logic [7:0] tq[$];
  int fails = 0, checked = 0, cyc = 0, u = 0;
  uof_event_flags #(.CYC_1MS(20), .CYC_IDLE(30)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .id_pin, .line_se0, .j_line_state, .line_diff,
    .bus_activity, .bus_idle, .above_a_session_end_threshold,
    .above_b_session_end_threshold, .above_a_vbus_valid_threshold,
    .stall_sent, .token_done, .token_info, .frame_start, .error_flags,
    .error_event_enables, .irq
  );
  uof_bus_partner bus (
    .aclk, .id_pin, .line_se0, .j_line_state, .line_diff, .bus_activity,
    .bus_idle, .above_a_session_end_threshold,
    .above_b_session_end_threshold, .above_a_vbus_valid_threshold
  );
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      summarize();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [3:0] s = 4'hF, input logic [1:0] er = UOF_RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("rresp", {30'h0, r}, {30'h0, UOF_RESP_OKAY});
    chk($sformatf("reg %h", a), d, e);
  endtask : rchk
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 24; a += 4) rchk(8'(a), 32'h0);
    rd(8'h18);
    chk("unmapped", {30'h0, r}, {30'h0, UOF_RESP_SLVERR});
    wr(8'h18, 32'hFFFFFFFF, 4'hF, UOF_RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr(UOF_OTG_ENABLES_ADDR, rnd);
      rchk(UOF_OTG_ENABLES_ADDR, rnd & 32'hFD);
      wr(UOF_USB_ENABLES_ADDR, rnd);
      rchk(UOF_USB_ENABLES_ADDR, rnd & 32'hFF);
    end
    wr(UOF_USB_ENABLES_ADDR, 32'h0, 4'h0);
    rchk(UOF_USB_ENABLES_ADDR, rnd & 32'hFF);
    wr(UOF_OTG_ENABLES_ADDR, 32'h0);
    wr(UOF_USB_ENABLES_ADDR, 32'h0);
    $display("test enables done");
    @(posedge aclk);
    {stall_sent, token_done, frame_start} <= 3'b111;
    token_info <= rnd[15:8];
    tq.push_back(rnd[15:8]);
    error_flags <= 8'h04;
    @(posedge aclk);
    {stall_sent, token_done, frame_start} <= 3'b000;
    u = 8'h8C;
    rchk(UOF_USB_FLAGS_ADDR, u);
    rchk(UOF_XFER_STATUS_ADDR, tq.pop_front());
    error_event_enables <= 8'h04;
    u = u | 8'h02;
    rchk(UOF_USB_FLAGS_ADDR, u);
    error_event_enables <= 8'h00;
    wr(UOF_USB_FLAGS_ADDR, 32'h88);
    u = u & 8'h06;
    rchk(UOF_USB_FLAGS_ADDR, u);
    wr(UOF_USB_ENABLES_ADDR, 32'h04);
    rchk(UOF_USB_FLAGS_ADDR, u);
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(UOF_USB_FLAGS_ADDR, 32'hFF);
    rchk(UOF_USB_FLAGS_ADDR, 32'h0);
    chk("irq off", {31'h0, irq}, 32'h0);
    $display("test engine done");
    bus.drive(8'h40, 60);
    rchk(UOF_USB_FLAGS_ADDR, 32'h01);
    wr(UOF_USB_FLAGS_ADDR, 32'h01);
    bus.drive(8'h40, 60);
    rchk(UOF_USB_FLAGS_ADDR, 32'h00);
    bus.drive(8'h20, 5);
    bus.drive(8'h40, 60);
    bus.drive(8'h00, 60);
    bus.drive(8'h28, 40);
    rchk(UOF_USB_FLAGS_ADDR, 32'h31);
    rchk(UOF_OTG_FLAGS_ADDR, 32'h0);
    wr(UOF_USB_FLAGS_ADDR, 32'hFF);
    $display("test line device done");
    bus.drive(8'h20, 1);
    wr(UOF_MODE_CTRL_ADDR, 32'h01);
    bus.drive(8'h20, 60);
    wr(UOF_OTG_FLAGS_ADDR, 32'hFF);
    bus.drive(8'hB7, 3);
    bus.drive(8'hA7, 2);
    bus.drive(8'h87, 30);
    rchk(UOF_OTG_FLAGS_ADDR, 32'hFD);
    wr(UOF_OTG_FLAGS_ADDR, 32'h0D);
    rd(UOF_OTG_FLAGS_ADDR);
    chk("otg clear", d & 32'h8D, 32'h80);
    bus.drive(8'h80, 5);
    rd(UOF_OTG_FLAGS_ADDR);
    chk("falling", d & 32'h8D, 32'h8D);
    bus.drive(8'hC0, 60);
    rd(UOF_USB_FLAGS_ADDR);
    chk("detach", d & 32'h41, 32'h41);
    wr(UOF_USB_ENABLES_ADDR, 32'h01);
    rchk(UOF_USB_ENABLES_ADDR, 32'h01);
    chk("irq detach", {31'h0, irq}, 32'h1);
    wr(UOF_USB_ENABLES_ADDR, 32'h00);
    wr(UOF_OTG_ENABLES_ADDR, 32'h80);
    rchk(UOF_OTG_ENABLES_ADDR, 32'h80);
    chk("irq otg", {31'h0, irq}, 32'h1);
    wr(UOF_MODE_CTRL_ADDR, 32'h00);
    rchk(UOF_MODE_CTRL_ADDR, 32'h00);
    chk("irq device", {31'h0, irq}, 32'h0);
    wr(UOF_USB_ENABLES_ADDR, 32'h40);
    rd(UOF_USB_FLAGS_ADDR);
    chk("attach hidden", d & 32'h40, 32'h0);
    chk("irq attach", {31'h0, irq}, 32'h0);
    $display("test host done");
    wr(UOF_USB_FLAGS_ADDR, 32'hFF);
    wr(UOF_MODE_CTRL_ADDR, 32'h02);
    bus.drive(8'h20, 60);
    rchk(UOF_USB_FLAGS_ADDR, 32'h20);
    $display("test low speed done");
    summarize();
  end
endmodule : tb

// *** sim/uof_bus_partner.sv ***
`timescale 1ns/1ns
module uof_bus_partner (
  // clock
  input wire logic aclk,
  // line and vbus levels
  output logic id_pin,
  output logic line_se0,
  output logic j_line_state,
  output logic line_diff,
  output logic bus_activity,
  output logic bus_idle,
  output logic above_a_session_end_threshold,
  output logic above_b_session_end_threshold,
  output logic above_a_vbus_valid_threshold
);
  // full speed: j is diff high, k diff low, neither during se0
  assign j_line_state = line_se0 ? 1'b0 : line_diff;
  initial begin
    {id_pin, line_se0, line_diff, bus_activity, bus_idle} = 5'b00100;
    above_a_session_end_threshold = 1'b0;
    above_b_session_end_threshold = 1'b0;
    above_a_vbus_valid_threshold = 1'b0;
  end
  // bits: id se0 diff activity idle a_end b_end a_valid
  task automatic drive(input logic [7:0] v, input int n);
    @(posedge aclk);
    {id_pin, line_se0, line_diff, bus_activity, bus_idle} <= v[7:3];
    above_a_session_end_threshold <= v[2];
    above_b_session_end_threshold <= v[1];
    above_a_vbus_valid_threshold <= v[0];
    repeat (n) @(posedge aclk);
  endtask : drive
endmodule : uof_bus_partner

// *** sim/uof_event_flags_sva.sv ***
`timescale 1ns/1ns
module uof_event_flags_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // token events
  input wire logic token_done,
  input wire logic [7:0] token_info
);
  import uof_pkg::*;
  logic [7:0] rd_addr_reg;
  logic [7:0] tok_reg;
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic w_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_reg <= 8'h00;
    end else if (ar_take) begin
      rd_addr_reg <= s_axi_araddr;
    end
  end
  // last token seen, as the status register should show it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tok_reg <= 8'h00;
    end else if (token_done) begin
      tok_reg <= token_info;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rd_answer;
    ar_take |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer missing");
  property p_wr_answer;
    w_take |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer missing");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data dropped");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped");
  property p_upper_zero;
    s_axi_rvalid && s_axi_rresp == UOF_RESP_OKAY
      |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper bits not zero");
  property p_otg_bit1;
    s_axi_rvalid && rd_addr_reg == UOF_OTG_FLAGS_ADDR |-> !s_axi_rdata[1];
  endproperty
  a_otg_bit1: assert property (p_otg_bit1)
    else $error("otg flag bit 1 set");
  property p_en_bit1;
    s_axi_rvalid && rd_addr_reg == UOF_OTG_ENABLES_ADDR |-> !s_axi_rdata[1];
  endproperty
  a_en_bit1: assert property (p_en_bit1)
    else $error("otg enable bit 1 set");
  property p_token;
    ar_take && s_axi_araddr == UOF_XFER_STATUS_ADDR && !token_done
      |=> s_axi_rdata[7:0] == tok_reg;
  endproperty
  a_token: assert property (p_token)
    else $error("status not last token");
  property p_slverr;
    ar_take && s_axi_araddr > UOF_MODE_CTRL_ADDR
      |=> s_axi_rresp == UOF_RESP_SLVERR;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped read not refused");
endmodule : uof_event_flags_chk

bind uof_event_flags uof_event_flags_chk u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .token_done, .token_info
);
